// *** rtl/clk_src_gen.sv ***
// oscillator models as tick dividers plus external source edge detect
module clk_src_gen #(
    parameter int RC8_DIVISOR = clk_sys_pkg::RC8_DIV,
    parameter int RC4_DIVISOR = clk_sys_pkg::RC4_DIV,
    parameter int WDT_DIVISOR = clk_sys_pkg::WDT_DIV
) (
    input  wire logic   CLK,
    input  wire logic   SYS_RST,
    input  wire logic   EXT_CLK_IN,
    input  wire logic   OSC_AMP_IN,
    clk_src_if.gen      src
);
    import clk_sys_pkg::*;
    logic [2:0] osc_tick;  // rc8, rc4, watchdog ticks
    logic       ext_d_r;   // external clock last level
    logic       amp_d_r;   // amplifier input last level

    // one divider per internal oscillator
    for (genvar i = 0; i < 3; i++) begin : g_osc
        localparam int DIV = (i == 0) ? RC8_DIVISOR : (i == 1) ? RC4_DIVISOR : WDT_DIVISOR;
        logic [15:0] cnt_r;
        // watchdog oscillator runs free, rc only while allowed
        always_ff @(posedge CLK) begin
            if (SYS_RST || (i != 2 && !src.run)) begin
                cnt_r <= 16'h0000;
            end else if (cnt_r == 16'(DIV - 1)) begin
                cnt_r <= 16'h0000;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
        assign osc_tick[i] = (i == 2 || src.run) && (cnt_r == 16'(DIV - 1));
    end

    // rising edge detect of external sources
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ext_d_r <= 1'b0;
            amp_d_r <= 1'b0;
        end else begin
            ext_d_r <= EXT_CLK_IN;
            amp_d_r <= OSC_AMP_IN;
        end
    end

    assign src.wdt_tick = osc_tick[2];
    assign src.amp_en   = src.sel[3] && src.run;

    // source multiplexer, reserved codes give no clock
    always_comb begin
        src.src_tick = 1'b0;
        if (src.sel[3]) begin
            src.src_tick = src.run && OSC_AMP_IN && !amp_d_r;
        end else begin
            case (src.sel)
                CKSEL_EXT: src.src_tick = src.run && EXT_CLK_IN && !ext_d_r;
                CKSEL_RC4: src.src_tick = osc_tick[1];
                CKSEL_RC8: src.src_tick = osc_tick[0];
                CKSEL_WDT: src.src_tick = osc_tick[2];
                default:   src.src_tick = 1'b0;
            endcase
        end
    end
endmodule

// *** rtl/clk_src_if.sv ***
// source selection and oscillator ticks between sequencer and sources
interface clk_src_if;
    logic [3:0] sel;      // latched source select
    logic       run;      // source oscillator allowed to run
    logic       src_tick; // one pulse per selected source cycle
    logic       wdt_tick; // one pulse per watchdog oscillator cycle
    logic       amp_en;   // crystal amplifier active
    modport gen  (input sel, run, output src_tick, wdt_tick, amp_en);
    modport user (output sel, run, input src_tick, wdt_tick, amp_en);
endinterface

// *** rtl/clk_sys_ctrl.sv ***
// clock select, prescale, gating and start-up sequencing
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
module clk_sys_ctrl #(
    parameter int LONG_TO_CYC  = clk_sys_pkg::LONG_TO_DEF,
    parameter int XT_WAKE_CYC  = clk_sys_pkg::XT_WAKE_DEF
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // fuse inputs, zero means programmed
    input  wire logic [3:0]  FUSE_CLOCK_SOURCE_SELECT,
    input  wire logic [1:0]  FUSE_STARTUP_TIME_SELECT,
    input  wire logic        FUSE_DIVIDE_BY_EIGHT_OPTION,
    // clock source pins
    input  wire logic        EXT_CLK_IN,
    input  wire logic        OSC_AMP_INPUT,
    output logic             OSC_AMP_OUTPUT,
    output logic             OSC_AMP_OUTPUT_OE,
    // wake sources
    input  wire logic        WAKE_IN,
    input  wire logic        ASYNC_INT_IN,
    input  wire logic        USI_SCL_IN,
    input  wire logic        USI_SDA_IN,
    // gated clock enables and free-running watchdog tick
    output logic             CORE_CLOCK_EN,
    output logic             PERIPHERAL_CLOCK_EN,
    output logic             PROGRAM_MEMORY_CLOCK_EN,
    output logic             WATCHDOG_TIMER_TICK,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP
);
    import clk_sys_pkg::*;

    clk_src_if  src ();                  // source carrier
    logic [3:0] cksel_r;                 // latched source select
    logic [1:0] sut_r;                   // latched start-up select
    logic       div_fuse_r;              // latched divide fuse
    logic       div8_on;                 // prescaler active
    logic       reserved_sel;            // select code has no source
    state_e     state_r;                 // sequencer state
    logic [CNT_W-1:0] cnt_r;             // start-up counter
    logic [CNT_W-1:0] rst_to_len;        // reset time-out length
    logic [CNT_W-1:0] wake_len;          // wake start-up length
    logic [2:0] presc_r;                 // divide-by-eight counter
    logic       sys_tick;                // generator output tick
    logic       core_gate_r;             // core clock gate
    logic       periph_gate_r;           // peripheral clock gate
    logic       pmem_gate_r;             // program memory clock gate
    logic       core_gate_nxt;
    logic       periph_gate_nxt;
    logic       pmem_gate_nxt;
    logic [2:0] ctrl_r;                  // core, periph, pmem off bits
    logic       sleep_cmd;               // sleep request pulse
    logic [1:0] sleep_kind;              // requested sleep
    logic       wake_seen_r;             // sticky wake flag
    logic       sda_d_r;                 // serial data last level
    logic       usi_start;               // serial start condition
    logic       async_wake;              // clock-free wake event
    logic       wr_pend_r;               // write data phase pending
    logic [7:0] addr_r;                  // data phase address
    logic [31:0] hrdata_r;               // read data register
    logic       addr_ok;                 // address phase accepted
    logic [31:0] status_w;               // status word

    // fuse latch, open only while reset is asserted
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cksel_r    <= FUSE_CLOCK_SOURCE_SELECT;
            sut_r      <= FUSE_STARTUP_TIME_SELECT;
            div_fuse_r <= FUSE_DIVIDE_BY_EIGHT_OPTION;
        end
    end

    // fuse decode
    assign div8_on      = !div_fuse_r;
    assign reserved_sel = !cksel_r[3] && cksel_r[0];

    // oscillator and source selection
    assign src.sel = cksel_r;
    assign src.run = (state_r != ST_PDOWN);
    clk_src_gen u_src (
        .CLK        (CLK),
        .SYS_RST    (SYS_RST),
        .EXT_CLK_IN (EXT_CLK_IN),
        .OSC_AMP_IN (OSC_AMP_INPUT),
        .src        (src)
    );

    // inverting amplifier drives the output pin for crystal codes
    assign OSC_AMP_OUTPUT    = !OSC_AMP_INPUT;
    assign OSC_AMP_OUTPUT_OE = src.amp_en;
    assign WATCHDOG_TIMER_TICK = src.wdt_tick;

    // reset time-out and wake lengths per start-up select
    always_comb begin
        rst_to_len = CNT_W'(LONG_TO_CYC);
        wake_len   = CNT_W'(RC_WAKE_CYC);
        if (cksel_r[3]) begin
            case ({cksel_r[0], sut_r})
                3'h0, 3'h3, 3'h6: rst_to_len = CNT_W'(SHORT_TO_CYC);
                3'h2, 3'h5:       rst_to_len = '0;
                default:          rst_to_len = CNT_W'(LONG_TO_CYC);
            endcase
            case ({cksel_r[0], sut_r})
                3'h0, 3'h1:       wake_len = CNT_W'(XT_WAKE_SHORT);
                3'h2, 3'h3, 3'h4: wake_len = CNT_W'(XT_WAKE_MED);
                default:          wake_len = CNT_W'(XT_WAKE_CYC);
            endcase
        end else begin
            case (sut_r)
                2'h0:    rst_to_len = '0;
                2'h1:    rst_to_len = CNT_W'(SHORT_TO_CYC);
                default: rst_to_len = CNT_W'(LONG_TO_CYC);
            endcase
        end
    end

    // clock-free wake detectors, not gated by the peripheral clock
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sda_d_r <= 1'b1;
        end else begin
            sda_d_r <= USI_SDA_IN;
        end
    end
    assign usi_start  = USI_SCL_IN && sda_d_r && !USI_SDA_IN;
    assign async_wake = ASYNC_INT_IN || usi_start;

    // start-up and sleep sequencer
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= ST_RST_WDT;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_RST_WDT: begin
                    if (rst_to_len == '0) begin
                        state_r <= ST_RST_CK;
                        cnt_r   <= '0;
                    end else if (src.wdt_tick) begin
                        if (cnt_r == rst_to_len - 1'b1) begin
                            state_r <= ST_RST_CK;
                            cnt_r   <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                end
                ST_RST_CK: begin
                    if (src.src_tick) begin
                        if (cnt_r == CNT_W'(RST_CK_CYC - 1)) begin
                            state_r <= ST_RUN;
                            cnt_r   <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (sleep_cmd && sleep_kind == SLEEP_IDLE) begin
                        state_r <= ST_IDLE;
                    end else if (sleep_cmd && sleep_kind == SLEEP_PDOWN) begin
                        state_r <= ST_PDOWN;
                    end
                end
                ST_IDLE: begin // no start-up, oscillator kept running
                    if (WAKE_IN || async_wake) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_PDOWN: begin
                    if (WAKE_IN || async_wake) begin
                        state_r <= ST_WAKE;
                        cnt_r   <= '0;
                    end
                end
                ST_WAKE: begin
                    if (src.src_tick) begin
                        if (cnt_r == wake_len - 1'b1) begin
                            state_r <= ST_RUN;
                            cnt_r   <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_RST_WDT;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // divide-by-eight prescaler in the clock generator
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            presc_r <= 3'h0;
        end else if (src.src_tick) begin
            presc_r <= presc_r + 3'h1;
        end
    end
    assign sys_tick = src.src_tick && (!div8_on || presc_r == 3'(PRESCALE_DIV - 1));

    // gate targets per state and software stop bits
    always_comb begin
        core_gate_nxt   = 1'b0;
        periph_gate_nxt = 1'b0;
        pmem_gate_nxt   = 1'b0;
        case (state_r)
            ST_RUN: begin
                core_gate_nxt   = !ctrl_r[0];
                periph_gate_nxt = !ctrl_r[1];
                pmem_gate_nxt   = !ctrl_r[0] && !ctrl_r[2];
            end
            ST_IDLE: begin
                periph_gate_nxt = !ctrl_r[1];
            end
            default: begin // start-up and power-down stop all
                core_gate_nxt = 1'b0;
            end
        endcase
    end

    // gates move only between generator pulses
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            core_gate_r   <= 1'b0;
            periph_gate_r <= 1'b0;
            pmem_gate_r   <= 1'b0;
        end else if (!sys_tick) begin
            core_gate_r   <= core_gate_nxt;
            periph_gate_r <= periph_gate_nxt;
            pmem_gate_r   <= pmem_gate_nxt;
        end
    end
    // a stop drops whole pulses at once, a start waits for the quiet gate update
    assign CORE_CLOCK_EN           = sys_tick && core_gate_r && core_gate_nxt;
    assign PERIPHERAL_CLOCK_EN     = sys_tick && periph_gate_r && periph_gate_nxt;
    assign PROGRAM_MEMORY_CLOCK_EN = sys_tick && pmem_gate_r && pmem_gate_nxt;

    // AHB-Lite address phase capture, word accesses only
    assign addr_ok   = HSEL && HTRANS[1] && HREADY && HSIZE == 3'h2;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else if (HREADY) begin
            wr_pend_r <= addr_ok && HWRITE;
            addr_r    <= HADDR[7:0];
        end
    end

    // control register write and sleep command pulse
    assign sleep_kind = HWDATA[SLEEP_LSB +: 2];
    assign sleep_cmd  = wr_pend_r && addr_r == CTRL_OFS;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_r <= CTRL_RST;
        end else if (sleep_cmd) begin
            ctrl_r <= HWDATA[PMEM_OFF_BIT:CORE_OFF_BIT];
        end
    end

    // sticky wake flag, set wins over write-one clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wake_seen_r <= 1'b0;
        end else if ((state_r == ST_PDOWN || state_r == ST_IDLE)
                     && (WAKE_IN || async_wake)) begin
            wake_seen_r <= 1'b1;
        end else if (wr_pend_r && addr_r == STATUS_OFS && HWDATA[STAT_WAKE_BIT]) begin
            wake_seen_r <= 1'b0;
        end
    end

    // status word and registered read data
    assign status_w = {19'h0, wake_seen_r, src.amp_en, 3'(state_r),
                       reserved_sel, div8_on, sut_r, cksel_r};
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
                CTRL_OFS:   hrdata_r <= {25'h0, ctrl_r, 4'h0};
                STATUS_OFS: hrdata_r <= status_w;
                default:    hrdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign HRDATA = hrdata_r;

    // checks
    a_core_startup_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r != ST_RUN |-> !CORE_CLOCK_EN) else $error("core clock outside run");
    a_pmem_with_core: assert property (@(posedge CLK) disable iff (SYS_RST)
        PROGRAM_MEMORY_CLOCK_EN |-> CORE_CLOCK_EN) else $error("pmem clock without core");
    a_idle_periph_runs: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_IDLE && $past(state_r) == ST_IDLE && sys_tick && !ctrl_r[1]
        && $past(!ctrl_r[1]) |-> PERIPHERAL_CLOCK_EN) else $error("periph halted in idle");
    a_fuse_hold_run: assert property (@(posedge CLK) disable iff (SYS_RST)
        $stable(cksel_r) && $stable(sut_r) && $stable(div_fuse_r)) else $error("fuse moved");
    a_amp_crystal: assert property (@(posedge CLK) disable iff (SYS_RST)
        OSC_AMP_OUTPUT_OE |-> cksel_r[3] && state_r != ST_PDOWN) else $error("amp misuse");
    a_reserved_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        reserved_sel |-> !sys_tick) else $error("reserved code ticks");
    a_prescale_gap: assert property (@(posedge CLK) disable iff (SYS_RST)
        sys_tick && div8_on |=> !sys_tick [*8]) else $error("prescale too fast");
    a_reset_wdt_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_RST_WDT && !src.wdt_tick && rst_to_len != '0
        |=> state_r == ST_RST_WDT) else $error("reset delay off watchdog");
    a_reset_len: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_RST_WDT && src.wdt_tick && cnt_r < rst_to_len - 1'b1
        |=> state_r == ST_RST_WDT) else $error("reset time-out short");
    a_wake_count: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_WAKE && src.src_tick && cnt_r == wake_len - 1'b1
        |=> state_r == ST_RUN) else $error("wake count missed");
    a_async_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_PDOWN && ASYNC_INT_IN |=> state_r == ST_WAKE) else $error("no wake");
    a_usi_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_PDOWN && usi_start |=> state_r == ST_WAKE) else $error("no usi wake");
    a_gate_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$stable(core_gate_r) |-> !$past(sys_tick)) else $error("gate changed on pulse");
    c_reach_run: cover property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_RST_CK ##1 state_r == ST_RUN);
    c_pdown_wake: cover property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_WAKE ##1 state_r == ST_RUN);
    c_idle_exit: cover property (@(posedge CLK) disable iff (SYS_RST)
        state_r == ST_IDLE ##1 state_r == ST_RUN);
endmodule

// *** rtl/clk_sys_pkg.sv ***
// Operation
// - peripheral and program-memory clocks can be stopped alone
// - halted core clock means no core activity
// - peripheral clock drives timers, serial, interrupts
// - some interrupts detected without peripheral clock
// - serial start detection works in every sleep
// - program-memory clock gated with core clock
// - four-bit source select decode, odd codes below 1000 reserved
// - fuse one means unprogrammed, zero programmed
// - selected source feeds the common clock generator
// - wake counts start-up on selected source
// - reset delay counted on watchdog oscillator
// - reset time-out is none, 512 or 8192 cycles
// - default select 0100, start-up 10, divide programmed
// - crystal codes enable the inverting amplifier
// - programmed option divides internal clock by eight
// - rc start-up: 6 wake, 14 plus time-out
package clk_sys_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] STATUS_OFS      = 8'h04;
    // control field positions
    localparam int         SLEEP_LSB       = 0;
    localparam int         CORE_OFF_BIT    = 4;
    localparam int         PERIPH_OFF_BIT  = 5;
    localparam int         PMEM_OFF_BIT    = 6;
    localparam logic [2:0] CTRL_RST        = 3'h0;
    // status field positions
    localparam int         STAT_STATE_LSB  = 8;
    localparam int         STAT_AMP_BIT    = 11;
    localparam int         STAT_WAKE_BIT   = 12;
    // sleep commands
    localparam logic [1:0] SLEEP_IDLE      = 2'h1;
    localparam logic [1:0] SLEEP_PDOWN     = 2'h2;
    // source select codes
    localparam logic [3:0] CKSEL_EXT       = 4'h0;
    localparam logic [3:0] CKSEL_RC4       = 4'h2;
    localparam logic [3:0] CKSEL_RC8       = 4'h4;
    localparam logic [3:0] CKSEL_WDT       = 4'h6;
    // shipped fuse values
    localparam logic [3:0] CKSEL_DEFAULT   = 4'h4;
    localparam logic [1:0] SUT_DEFAULT     = 2'h2;
    localparam logic       DIV8_DEFAULT    = 1'b0;
    // start-up counts in oscillator cycles
    localparam int         RST_CK_CYC      = 14;
    localparam int         SHORT_TO_CYC    = 512;
    localparam int         LONG_TO_DEF     = 8192;
    localparam int         RC_WAKE_CYC     = 6;
    localparam int         XT_WAKE_SHORT   = 258;
    localparam int         XT_WAKE_MED     = 1024;
    localparam int         XT_WAKE_DEF     = 16384;
    localparam int         PRESCALE_DIV    = 8;
    // oscillator rates against the system clock
    localparam int         CLK_HZ          = 100_000_000;
    localparam int         RC8_HZ          = 8_000_000;
    localparam int         RC4_HZ          = 4_000_000;
    localparam int         WDT_HZ          = 128_000;
    localparam int         RC8_DIV         = CLK_HZ / RC8_HZ;
    localparam int         RC4_DIV         = CLK_HZ / RC4_HZ;
    localparam int         WDT_DIV         = CLK_HZ / WDT_HZ;
    localparam int         CNT_W           = 16;
    // sequencer states
    typedef enum logic [2:0] {
        ST_RST_WDT, ST_RST_CK, ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE
    } state_e;
endpackage

// *** verif/system_clock_select_startup_tb.sv ***
module system_clock_select_startup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_sys_pkg::*;
    `define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
        $display("wrong value %s exp %0h got %0h", n, e, a); end end
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [3:0]  sel = 4'h4;                                 // fuse source code
    logic [1:0]  startup_time_select = 2'h2;                                 // fuse start-up code
    logic        div = 1'b0;                                 // fuse divide, 0 = on
    logic        ext = 1'b0, amp = 1'b0, wake = 1'b0, aint = 1'b0, scl = 1'b1, sda = 1'b1;
    logic        hsel = 1'b0, hw = 1'b0;
    logic [1:0]  htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, q;
    logic [7:0]  cyc = 8'h00;                                // source stimulus counter
    logic [3:0]  cs [4] = '{4'h0, 4'h2, 4'h4, 4'h6};
    int          cg [4] = '{8, RC4_DIV, RC8_DIV, WDT_DIV};   // expected pulse spacing
    wire         amp_o, amp_oe, cen, pen, men, hro, hrsp, wdt;
    wire  [31:0] hrd;
    int          fail_count = 0, tests_run = 0, n, j, k;
    // clock and source stimuli: ext rises every 8, amp every 16 cycles
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 8'h01;
        ext <= cyc[2];
        amp <= cyc[3];
    end
    clk_sys_ctrl #(.LONG_TO_CYC(64), .XT_WAKE_CYC(64)) clk_sys_ctrl_inst (
        .CLK(CLK), .SYS_RST(SYS_RST), .FUSE_CLOCK_SOURCE_SELECT(sel),
        .FUSE_STARTUP_TIME_SELECT(startup_time_select), .FUSE_DIVIDE_BY_EIGHT_OPTION(div), .EXT_CLK_IN(ext),
        .OSC_AMP_INPUT(amp), .OSC_AMP_OUTPUT(amp_o), .OSC_AMP_OUTPUT_OE(amp_oe),
        .WAKE_IN(wake), .ASYNC_INT_IN(aint), .USI_SCL_IN(scl), .USI_SDA_IN(sda),
        .CORE_CLOCK_EN(cen), .PERIPHERAL_CLOCK_EN(pen), .PROGRAM_MEMORY_CLOCK_EN(men),
        .WATCHDOG_TIMER_TICK(wdt), .HSEL(hsel), .HADDR(ha), .HTRANS(htr), .HWRITE(hw),
        .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hro), .HREADYOUT(hro), .HRDATA(hrd), .HRESP(hrsp));
    // verdict and end of run
    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // bounded wait for the slave's ready
    task automatic rdy;
        int t;
        t = 0;
        do begin @(posedge CLK); t++; end while (hro !== 1'b1 && t < 20);
        if (hro !== 1'b1) begin fail_count++; tally_and_finish; end
    endtask
    // one single-word transfer, read data left in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htr <= 2'h2; hw <= w; ha <= {24'h000000, a};
        rdy;
        htr <= 2'h0; hsel <= 1'b0; hwd <= d;
        rdy;
        q = hrd;
    endtask
    // reset with given fuses, held 16 cycles
    task automatic rst(input logic [3:0] s, input logic [1:0] u, input logic d);
        @(posedge CLK);
        sel <= s; startup_time_select <= u; div <= d; SYS_RST <= 1'b1;
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
    endtask
    // poll the sequencer state until it matches, c = cycles spent
    task automatic to_state(input logic [2:0] st, input int lim, output int c);
        c = 0;
        do begin bus(1'b0, STATUS_OFS, 32'h0); c += 2; end while (q[10:8] !== st && c < lim);
        if (q[10:8] !== st) begin fail_count++; tally_and_finish; end
    endtask
    // spacing between two pulses of enable i, 0 when none come
    task automatic gap(input int i, output int g);
        logic [3:0] e;
        int f;
        g = 0; f = -1;
        for (int t = 0; t < 1600; t++) begin
            @(posedge CLK);
            e = {wdt, men, pen, cen};
            if (e[i] === 1'b1 && f >= 0) begin g = t - f; break; end
            if (e[i] === 1'b1) f = t;
        end
    endtask
    // shipped fuses: decode, watchdog-timed reset delay, divided clock
    task automatic t_default;
        rst(4'h4, 2'h2, 1'b0);
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("sel", 4'h4, q[3:0])
        `CHK("sut", 2'h2, q[5:4])
        `CHK("div", 1'b1, q[6])
        `CHK("state", 3'h0, q[10:8])
        `CHK("core off", 1'b0, cen)
        to_state(3'h2, 60000, n);
        `CHK("delay", 1'b1, n > 64 * 781 && n < 64 * 781 + 14 * 96 + 1600)
        gap(0, n);
        `CHK("div gap", 96, n)
        gap(3, n);
        `CHK("wdt tick", WDT_DIV, n)
    endtask
    // external, rc4, rc8 and watchdog codes: pulse spacing of core and peripheral clocks
    task automatic t_sources;
        for (j = 0; j < 4; j++) begin
            rst(cs[j], 2'h0, 1'b1);
            to_state(3'h2, 12000, n);
            `CHK("sel", cs[j], q[3:0])
            gap(0, n);
            `CHK("core gap", cg[j], n)
            gap(1, n);
            `CHK("periph gap", cg[j], n)
        end
    endtask
    // each stop bit set alone, unmapped read
    task automatic t_gating;
        rst(4'h4, 2'h0, 1'b1);
        to_state(3'h2, 3000, n);
        bus(1'b1, CTRL_OFS, 32'h10);
        gap(0, n); `CHK("core halt", 0, n)
        gap(1, n); `CHK("periph run", 12, n)
        bus(1'b1, CTRL_OFS, 32'h20);
        gap(1, n); `CHK("periph halt", 0, n)
        bus(1'b1, CTRL_OFS, 32'h40);
        gap(2, n); `CHK("pmem halt", 0, n)
        gap(0, n); `CHK("core run", 12, n)
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
    endtask
    // power-down left by wake pin, clock-free interrupt and serial start
    task automatic t_wake;
        for (j = 0; j < 3; j++) begin
            bus(1'b1, CTRL_OFS, {30'h0, SLEEP_PDOWN});
            bus(1'b0, STATUS_OFS, 32'h0);
            `CHK("pdown", 3'h4, q[10:8])
            if (j == 0) wake <= 1'b1;
            else if (j == 1) aint <= 1'b1;
            else sda <= 1'b0;
            for (k = 0; k < 300; k++) begin @(posedge CLK); if (cen === 1'b1) break; end
            wake <= 1'b0; aint <= 1'b0; sda <= 1'b1;
            `CHK("wake time", 1'b1, k >= 66 && k <= 90)
            if (k == 300) tally_and_finish;
            bus(1'b0, STATUS_OFS, 32'h0);
            `CHK("wake seen", 1'b1, q[12])
            bus(1'b1, STATUS_OFS, 32'h1000);
        end
    endtask
    // idle: core halted, peripheral clock runs, a wake returns at once
    task automatic t_idle;
        bus(1'b1, CTRL_OFS, {30'h0, SLEEP_IDLE});
        gap(0, n); `CHK("idle core", 0, n)
        gap(1, n); `CHK("idle periph", 12, n)
        aint <= 1'b1;
        @(posedge CLK);
        aint <= 1'b0;
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("idle exit", 3'h2, q[10:8])
    endtask
    // crystal amplifier, fuses held at run time, reserved code
    task automatic t_crystal;
        rst(4'hF, 2'h1, 1'b1);
        @(posedge CLK);
        `CHK("amp oe", 1'b1, amp_oe)
        `CHK("amp out", ~amp, amp_o)
        to_state(3'h2, 2000, n);
        gap(0, n); `CHK("xtal gap", 16, n)
        sel <= 4'h2;
        bus(1'b1, CTRL_OFS, {30'h0, SLEEP_PDOWN});
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("held sel", 4'hF, q[3:0])
        `CHK("amp stop", 1'b0, amp_oe)
        rst(4'h1, 2'h0, 1'b1);
        repeat (200) @(posedge CLK);
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("reserved", 3'h1, q[10:8])
    endtask
    initial begin
        t_default;
        t_sources;
        t_gating;
        t_wake;
        t_idle;
        t_crystal;
        tally_and_finish;
    end
endmodule
